/* File: aix_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module aix_host_model (
    input wire logic clk,
    input wire logic [7:0] rdData,
    output var aix_pkg::aix_req_type req
);
    initial req = '0;
    // byte write, strobe held until the taken edge, bus scrambled on release
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wrData <= d;
        req.wrEn <= 1'b1;
        @(posedge clk);
        req.wrEn <= 1'b0;
        req.addr <= ~a;
        req.wrData <= ~d;
    endtask
    // byte read, answer taken one cycle after the strobe edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rdEn <= 1'b1;
        @(posedge clk);
        req.rdEn <= 1'b0;
        req.addr <= ~a;
        #1 d = rdData; // sample the read byte 1 ns after the edge
    endtask
endmodule
`default_nettype wire

/* File: aix_irq_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module aix_irq_unit (
    input wire logic clk,
    input wire logic resetn,
    input wire aix_pkg::aix_src_type src,
    input wire aix_pkg::aix_req_type req,
    output logic [7:0] regRdData_r,
    output logic intPinOut_r,
    output logic intPinOe_r
);
    // per-bit trigger from condition, previous condition and mode code
    function automatic logic [7:0] trigVec(input logic [7:0] cond, input logic [7:0] prev,
                                           input logic [7:0] modeH, input logic [7:0] modeL);
        logic [7:0] t;
        t = 8'h00;
        for (int i = 0; i < 8; i++) begin
            unique case ({modeH[i], modeL[i]}) // [R6]
                aix_pkg::MODE_RISE: t[i] = cond[i] & ~prev[i]; // [R7]
                aix_pkg::MODE_FALL: t[i] = ~cond[i] & prev[i]; // [R7]
                aix_pkg::MODE_LEVEL: t[i] = cond[i]; // [R7]
                default: t[i] = 1'b0;
            endcase
        end
        return t;
    endfunction

    function automatic logic [7:0] regWrite(input aix_pkg::aix_req_type r, input logic [6:0] a,
                                            input logic [7:0] cur, input logic [7:0] valid);
        return (r.wrEn && r.addr == a) ? (r.wrData & valid) : cur;
    endfunction

    logic [7:0] stat1_r, stat2_r, mask1_r, mask2_r;
    logic [7:0] mode1H_r, mode1L_r, mode2H_r, mode2L_r;
    logic [7:0] prev1_r, prev2_r;
    logic [1:0] pol_r;
    logic [7:0] mask1_nxt, mask2_nxt, stat1_nxt, stat2_nxt;
    logic [7:0] cond1, cond2, trig1, trig2;
    logic rdStat1, rdStat2, irqActive;

    always_comb begin
        cond1 = 8'h00;
        cond1[aix_pkg::BIT_TX_SLIP] = src.txSampleSlip // [R10]
            | (src.txBlockSync & ~src.txBlockSyncIsOutput); // [R11]
        cond1[aix_pkg::BIT_OUT_SLIP] = src.outPortSlip & ~src.outPortMaster; // [R12]
        cond1[aix_pkg::BIT_CS_D_TO_E] = src.csDtoEDone; // [R13]
        cond1[aix_pkg::BIT_CS_E_TO_F] = src.csEtoFDone; // [R13]
        cond1[aix_pkg::BIT_RX_FAULT] = src.receiverFaultFlag; // [R14]
        cond2 = 8'h00;
        cond2[aix_pkg::BIT_UD_D_TO_E] = src.udDtoEDone & src.udBlockMode; // [R15]
        cond2[aix_pkg::BIT_UD_E_TO_F] = src.udEtoFDone & src.udBlockMode; // [R15]
        cond2[aix_pkg::BIT_Q_SUBCODE] = src.qSubcodeReady; // [R16]
    end

    assign trig1 = trigVec(cond1, prev1_r, mode1H_r, mode1L_r);
    assign trig2 = trigVec(cond2, prev2_r, mode2H_r, mode2L_r); // [R21]
    assign rdStat1 = req.rdEn && req.addr == aix_pkg::ADDR_STATUS1;
    assign rdStat2 = req.rdEn && req.addr == aix_pkg::ADDR_STATUS2;
    assign mask1_nxt = regWrite(req, aix_pkg::ADDR_MASK1, mask1_r, aix_pkg::VALID1);
    assign mask2_nxt = regWrite(req, aix_pkg::ADDR_MASK2, mask2_r, aix_pkg::VALID2);

    // set wins over the read clear; level bits re-set while the source holds
    assign stat1_nxt = ((rdStat1 ? 8'h00 : stat1_r) | trig1) // [R1] [R2]
        & mask1_nxt & aix_pkg::VALID1; // [R3] [R5] [R18]
    assign stat2_nxt = ((rdStat2 ? 8'h00 : stat2_r) | trig2) // [R1] [R2]
        & mask2_nxt & aix_pkg::VALID2; // [R3] [R5] [R19]
    assign irqActive = (stat1_r != 8'h00) || (stat2_r != 8'h00); // [R22]

    // status registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat1_r <= aix_pkg::RESET_BYTE; // [R3]
            stat2_r <= aix_pkg::RESET_BYTE; // [R3]
        end else begin
            stat1_r <= stat1_nxt;
            stat2_r <= stat2_nxt;
        end
    end

    // previous source conditions for edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev1_r <= aix_pkg::RESET_BYTE;
            prev2_r <= aix_pkg::RESET_BYTE;
        end else begin
            prev1_r <= cond1;
            prev2_r <= cond2;
        end
    end

    // masks, modes and pin polarity
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask1_r <= aix_pkg::RESET_BYTE; // [R4]
            mask2_r <= aix_pkg::RESET_BYTE; // [R4]
            mode1H_r <= aix_pkg::RESET_BYTE; // [R9]
            mode1L_r <= aix_pkg::RESET_BYTE; // [R9]
            mode2H_r <= aix_pkg::RESET_BYTE; // [R21]
            mode2L_r <= aix_pkg::RESET_BYTE; // [R21]
            pol_r <= aix_pkg::RESET_POL; // [R20]
        end else begin
            mask1_r <= mask1_nxt; // [R4]
            mask2_r <= mask2_nxt; // [R4]
            mode1H_r <= regWrite(req, aix_pkg::ADDR_MODE1_HIGH, mode1H_r, aix_pkg::VALID1);
            mode1L_r <= regWrite(req, aix_pkg::ADDR_MODE1_LOW, mode1L_r, aix_pkg::VALID1);
            mode2H_r <= regWrite(req, aix_pkg::ADDR_MODE2_HIGH, mode2H_r, aix_pkg::VALID2);
            mode2L_r <= regWrite(req, aix_pkg::ADDR_MODE2_LOW, mode2L_r, aix_pkg::VALID2);
            if (req.wrEn && req.addr == aix_pkg::ADDR_CONTROL1) begin
                pol_r <= req.wrData[aix_pkg::POL_LSB +: 2]; // [R20]
            end
        end
    end

    // read data, one cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdData_r <= aix_pkg::RESET_BYTE;
        end else if (req.rdEn) begin
            unique case (req.addr)
                aix_pkg::ADDR_CONTROL1: regRdData_r <= {5'h00, pol_r, 1'b0};
                aix_pkg::ADDR_STATUS1: regRdData_r <= stat1_r; // [R1]
                aix_pkg::ADDR_STATUS2: regRdData_r <= stat2_r; // [R1]
                aix_pkg::ADDR_MASK1: regRdData_r <= mask1_r;
                aix_pkg::ADDR_MODE1_HIGH: regRdData_r <= mode1H_r;
                aix_pkg::ADDR_MODE1_LOW: regRdData_r <= mode1L_r;
                aix_pkg::ADDR_MASK2: regRdData_r <= mask2_r;
                aix_pkg::ADDR_MODE2_HIGH: regRdData_r <= mode2H_r;
                aix_pkg::ADDR_MODE2_LOW: regRdData_r <= mode2L_r;
                default: regRdData_r <= 8'h00;
            endcase
        end
    end

    // pin drive; level follows pending status, active level set only by the polarity field
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            intPinOut_r <= 1'b0;
            intPinOe_r <= 1'b1;
        end else begin
            unique case (aix_pkg::aix_pol_type'(pol_r)) // [R8] [R20]
                aix_pkg::POL_ACTIVE_HIGH: begin
                    intPinOut_r <= irqActive; // [R22]
                    intPinOe_r <= 1'b1;
                end
                aix_pkg::POL_ACTIVE_LOW: begin
                    intPinOut_r <= ~irqActive; // [R22]
                    intPinOe_r <= 1'b1;
                end
                aix_pkg::POL_OPEN_DRAIN: begin
                    intPinOut_r <= 1'b0;
                    intPinOe_r <= irqActive; // [R22]
                end
                aix_pkg::POL_RESERVED: begin
                    intPinOut_r <= 1'b0;
                    intPinOe_r <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_SET_ON_TRIGGER: assert property ( // [R1]
        ((trig1 & mask1_nxt) != 8'h00) |=> ((stat1_r & $past(trig1 & mask1_nxt))
            == $past(trig1 & mask1_nxt)))
        else $error("triggered unmasked event not latched");
    AST_READ_CLEARS: assert property ( // [R2]
        (rdStat1 && trig1 == 8'h00 && !rdStat2 && trig2 == 8'h00) |=> (stat1_r == 8'h00))
        else $error("status one not cleared by read");
    AST_READ_RETURNS: assert property ( // [R1]
        rdStat2 |=> (regRdData_r == $past(stat2_r)))
        else $error("status two read data wrong");
    AST_MASKED_ZERO: assert property ( // [R3]
        ((stat1_r & ~mask1_r) == 8'h00) && ((stat2_r & ~mask2_r) == 8'h00))
        else $error("masked status bit set");
    AST_RESERVED_ZERO: assert property ( // [R18]
        ((stat1_r & ~aix_pkg::VALID1) == 8'h00) && ((stat2_r & ~aix_pkg::VALID2) == 8'h00))
        else $error("reserved status bit set");
    AST_LEVEL_HOLDS: assert property ( // [R7]
        (rdStat1 && mode1H_r[0] && !mode1L_r[0] && mask1_nxt[0] && src.receiverFaultFlag)
            |=> stat1_r[0])
        else $error("level bit cleared while source true");
    AST_RISING_ONLY: assert property ( // [R9]
        (!mode1H_r[2] && !mode1L_r[2] && mask1_nxt[2] && !src.csDtoEDone
            && $past(src.csDtoEDone) && rdStat1) |=> !stat1_r[2])
        else $error("rising mode fired on falling edge");
    AST_MASTER_NO_SLIP: assert property ( // [R12]
        (src.outPortMaster && $past(src.outPortMaster) && !stat1_r[6]) |=> !stat1_r[6])
        else $error("output slip set in master mode");
    AST_PIN_LEVEL: assert property ( // [R22]
        (pol_r == 2'h1 && $past(pol_r) == 2'h1) |-> (intPinOut_r == !$past(irqActive)))
        else $error("active low pin level wrong");
    AST_OPEN_DRAIN: assert property ( // [R20]
        (pol_r == 2'h2 && $past(pol_r) == 2'h2)
            |-> (!intPinOut_r && intPinOe_r == $past(irqActive)))
        else $error("open drain drive wrong");

    AST_SET_ON_TRIGGER2: assert property ( // [R1]
        ((trig2 & mask2_nxt) != 8'h00) |=> ((stat2_r & $past(trig2 & mask2_nxt))
            == $past(trig2 & mask2_nxt)))
        else $error("triggered unmasked group two event not latched");

    AST_READ_CLEARS2: assert property ( // [R2]
        (rdStat2 && trig2 == 8'h00)
            |=> (stat2_r == 8'h00))
        else $error("status two not cleared by read");

    AST_READ_RETURNS1: assert property ( // [R1]
        rdStat1
            |=> (regRdData_r == $past(stat1_r)))
        else $error("status one read data wrong");

    AST_KEEP1: assert property ( // [R1]
        !rdStat1 |=> ((stat1_r & $past(stat1_r & mask1_nxt))
            == $past(stat1_r & mask1_nxt)))
        else $error("status one bit lost without a read");

    AST_KEEP2: assert property ( // [R1]
        !rdStat2 |=> ((stat2_r & $past(stat2_r & mask2_nxt))
            == $past(stat2_r & mask2_nxt)))
        else $error("status two bit lost without a read");

    AST_ONLY_FROM_TRIGGER1: assert property ( // [R1]
        1'b1
            |=> ((stat1_r & ~$past(stat1_r | trig1)) == 8'h00))
        else $error("status one bit set without a trigger");

    AST_ONLY_FROM_TRIGGER2: assert property ( // [R1]
        1'b1
            |=> ((stat2_r & ~$past(stat2_r | trig2)) == 8'h00))
        else $error("status two bit set without a trigger");

    AST_MASK1_WRITE: assert property ( // [R4]
        (req.wrEn && req.addr == aix_pkg::ADDR_MASK1)
            |=> (mask1_r == ($past(req.wrData) & aix_pkg::VALID1)))
        else $error("mask one write not taken");

    AST_MASK2_WRITE: assert property ( // [R4]
        (req.wrEn && req.addr == aix_pkg::ADDR_MASK2)
            |=> (mask2_r == ($past(req.wrData) & aix_pkg::VALID2)))
        else $error("mask two write not taken");

    AST_MASK1_HOLD: assert property ( // [R4]
        !(req.wrEn && req.addr == aix_pkg::ADDR_MASK1)
            |=> $stable(mask1_r))
        else $error("mask one changed without a write");

    AST_MASK2_HOLD: assert property ( // [R4]
        !(req.wrEn && req.addr == aix_pkg::ADDR_MASK2)
            |=> $stable(mask2_r))
        else $error("mask two changed without a write");

    AST_MODE1H_WRITE: assert property ( // [R6]
        (req.wrEn && req.addr == aix_pkg::ADDR_MODE1_HIGH)
            |=> (mode1H_r == ($past(req.wrData) & aix_pkg::VALID1)))
        else $error("mode one high write not taken");

    AST_MODE1L_WRITE: assert property ( // [R6]
        (req.wrEn && req.addr == aix_pkg::ADDR_MODE1_LOW)
            |=> (mode1L_r == ($past(req.wrData) & aix_pkg::VALID1)))
        else $error("mode one low write not taken");

    AST_MODE2H_WRITE: assert property ( // [R21]
        (req.wrEn && req.addr == aix_pkg::ADDR_MODE2_HIGH)
            |=> (mode2H_r == ($past(req.wrData) & aix_pkg::VALID2)))
        else $error("mode two high write not taken");

    AST_MODE2L_WRITE: assert property ( // [R21]
        (req.wrEn && req.addr == aix_pkg::ADDR_MODE2_LOW)
            |=> (mode2L_r == ($past(req.wrData) & aix_pkg::VALID2)))
        else $error("mode two low write not taken");

    AST_RESERVED_MODE: assert property ( // [R6]
        ((mode1H_r & mode1L_r & trig1) == 8'h00)
            && ((mode2H_r & mode2L_r & trig2) == 8'h00))
        else $error("reserved mode code triggered");

    AST_FAULT_RISE: assert property ( // [R14]
        (!mode1H_r[0] && !mode1L_r[0] && mask1_nxt[0] && src.receiverFaultFlag
            && !prev1_r[0]) |=> stat1_r[0])
        else $error("receiver fault rise not latched");

    AST_FAULT_FALL: assert property ( // [R7]
        (!mode1H_r[0] && mode1L_r[0] && mask1_nxt[0] && !src.receiverFaultFlag
            && prev1_r[0]) |=> stat1_r[0])
        else $error("receiver fault fall not latched");

    AST_TX_SLIP_FIRES: assert property ( // [R10]
        (!mode1H_r[7] && !mode1L_r[7] && mask1_nxt[7] && src.txSampleSlip
            && !prev1_r[7]) |=> stat1_r[7])
        else $error("transmit slip not latched");

    AST_BLOCK_SYNC_OUT: assert property ( // [R11]
        (src.txBlockSyncIsOutput && !src.txSampleSlip && !prev1_r[7] && !stat1_r[7])
            |=> !stat1_r[7])
        else $error("block sync fired while pin is output");

    AST_OUT_SLIP_FIRES: assert property ( // [R12]
        (!mode1H_r[6] && !mode1L_r[6] && mask1_nxt[6] && src.outPortSlip
            && !src.outPortMaster && !prev1_r[6]) |=> stat1_r[6])
        else $error("output slip not latched in slave mode");

    AST_CS_FIRES: assert property ( // [R13]
        (!mode1H_r[1] && !mode1L_r[1] && mask1_nxt[1] && src.csEtoFDone
            && !prev1_r[1]) |=> stat1_r[1])
        else $error("channel status transfer not latched");

    AST_UD_FIRES: assert property ( // [R15]
        (!mode2H_r[3] && !mode2L_r[3] && mask2_nxt[3] && src.udDtoEDone
            && src.udBlockMode && !prev2_r[3]) |=> stat2_r[3])
        else $error("user buffer transfer not latched");

    AST_UD_NO_BLOCK: assert property ( // [R15]
        (!src.udBlockMode && prev2_r[3:2] == 2'b00 && stat2_r[3:2] == 2'b00)
            |=> (stat2_r[3:2] == 2'b00))
        else $error("user buffer event outside block mode");

    AST_Q_FIRES: assert property ( // [R16]
        (!mode2H_r[1] && !mode2L_r[1] && mask2_nxt[1] && src.qSubcodeReady
            && !prev2_r[1]) |=> stat2_r[1])
        else $error("q-subcode block not latched");

    AST_PIN_HIGH: assert property ( // [R20]
        (pol_r == 2'h0 && $past(pol_r) == 2'h0)
            |-> (intPinOut_r == $past(irqActive) && intPinOe_r))
        else $error("active high pin level wrong");

    AST_PIN_RESERVED: assert property ( // [R20]
        ($past(pol_r) == 2'h3)
            |-> (!intPinOut_r && !intPinOe_r))
        else $error("reserved polarity pin driven");

    AST_POL_WRITE: assert property ( // [R20]
        (req.wrEn && req.addr == aix_pkg::ADDR_CONTROL1)
            |=> (pol_r == $past(req.wrData[aix_pkg::POL_LSB +: 2])))
        else $error("polarity write not taken");

    AST_CTRL_READ: assert property ( // [R20]
        (req.rdEn && req.addr == aix_pkg::ADDR_CONTROL1)
            |=> (regRdData_r == {5'h00, $past(pol_r), 1'b0}))
        else $error("polarity read data wrong");

    COV_READ_CLEAR: cover property (stat1_r != 8'h00 ##1 rdStat1 ##1 stat1_r == 8'h00);
    COV_LEVEL: cover property (rdStat1 && mode1H_r[0] && stat1_r[0] ##1 stat1_r[0]);
    COV_Q_SUBCODE: cover property (stat2_r[1] ##1 intPinOe_r && pol_r == 2'h2);
    COV_FALLING: cover property (mode1L_r[7] && $fell(cond1[7]) ##1 stat1_r[7]);
endmodule
`default_nettype wire

/* File: aix_irq_unit_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module aix_irq_unit_tb;
    logic clk;
    logic resetn;
    aix_pkg::aix_src_type src;
    aix_pkg::aix_req_type req;
    logic [7:0] rdData;
    logic pinOut;
    logic pinOe;
    logic [7:0] got;
    int badCount = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [6:0] tAddr[9] = '{7'h07, 7'h07, 7'h07, 7'h07, 7'h07, 7'h07, 7'h08, 7'h08, 7'h08};
    int tBit[9] = '{7, 7, 6, 2, 1, 0, 3, 2, 1};
    logic [7:0] vExp[6] = '{8'hc7, 8'hc7, 8'hc7, 8'h0e, 8'h0e, 8'h0e};

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    aix_irq_unit i_aix_irq_unit (.clk(clk), .resetn(resetn), .src(src), .req(req),
        .regRdData_r(rdData), .intPinOut_r(pinOut), .intPinOe_r(pinOe));
    aix_host_model i_aix_host_model (.clk(clk), .rdData(rdData), .req(req));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            badCount++;
            give_verdict();
        end
    end
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        i_aix_host_model.rd(a, got);
        chk8($sformatf("reg %h", a), e, got);
    endtask
    task automatic fire(input int k, input logic v);
        case (k)
            0: src.txSampleSlip <= v;
            1: src.txBlockSync <= v;
            2: src.outPortSlip <= v;
            3: src.csDtoEDone <= v;
            4: src.csEtoFDone <= v;
            5: src.receiverFaultFlag <= v;
            6: src.udDtoEDone <= v;
            7: src.udEtoFDone <= v;
            default: src.qSubcodeReady <= v;
        endcase
    endtask
    // one-cycle pulse, then pin, status, clear on read and pin release
    task automatic ev(input int k, input logic [7:0] e);
        @(posedge clk);
        fire(k, 1'b1);
        @(posedge clk);
        fire(k, 1'b0);
        repeat (2) @(posedge clk);
        #1 chk1("pin", e != 8'h00, pinOut);
        rdchk(tAddr[k], e);
        rdchk(tAddr[k], 8'h00);
        #1 chk1("pin idle", 1'b0, pinOut);
    endtask

    initial begin
        src = '0;
        src.udBlockMode = 1'b1;
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1 chk1("oe", 1'b1, pinOe);
        for (int a = 0; a < 16; a++) rdchk(7'(a), 8'h00);
        rdchk(7'h7f, 8'h00);
        for (int i = 0; i < 6; i++) begin
            i_aix_host_model.wr(7'(9 + i), 8'hff);
            rdchk(7'(9 + i), vExp[i]);
            i_aix_host_model.wr(7'(9 + i), 8'h00);
        end
        i_aix_host_model.wr(7'h07, 8'hff);
        rdchk(7'h07, 8'h00);
        i_aix_host_model.wr(7'h09, aix_pkg::VALID1);
        i_aix_host_model.wr(7'h0c, aix_pkg::VALID2);
        for (int k = 0; k < 9; k++)
            ev(k, 8'(1 << tBit[k]));
        src.txBlockSyncIsOutput <= 1'b1;
        src.outPortMaster <= 1'b1;
        src.udBlockMode <= 1'b0;
        i_aix_host_model.wr(7'h09, 8'h80);
        i_aix_host_model.wr(7'h0c, 8'h0c);
        for (int k = 1; k < 9; k++) ev(k, 8'h00);
        i_aix_host_model.wr(7'h09, 8'h01);
        i_aix_host_model.wr(7'h0b, 8'h01);
        src.receiverFaultFlag <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(7'h07, 8'h00);
        src.receiverFaultFlag <= 1'b0;
        repeat (3) @(posedge clk);
        rdchk(7'h07, 8'h01);
        i_aix_host_model.wr(7'h0a, 8'h01);
        i_aix_host_model.wr(7'h0b, 8'h00);
        src.receiverFaultFlag <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(7'h07, 8'h01);
        rdchk(7'h07, 8'h01);
        for (int p = 0; p < 4; p++) begin
            i_aix_host_model.wr(7'h01, 8'(p << 1));
            repeat (2) @(posedge clk);
            #1 chk1("pin level", p == 0, pinOut);
            chk1("pin enable", p != 3, pinOe);
        end
        i_aix_host_model.wr(7'h01, 8'h00);
        src.receiverFaultFlag <= 1'b0;
        repeat (2) @(posedge clk);
        i_aix_host_model.rd(7'h07, got);
        rdchk(7'h07, 8'h00);
        #1 chk1("pin off", 1'b0, pinOut);
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: aix_pkg.sv */
// Function
// [R1] a status bit reads 1 if its event occurred since the last read
// [R2] reading status clears it, except level-mode bits whose source is still true
// [R3] masked status bits always read 0; both status registers reset to zero
// [R4] mask 1 lets a source set status and drive the pin; masks reset zero
// [R5] each mask bit gates the status bit in the same position
// [R6] high and low mode bits form code: 00 rise, 01 fall, 10 level, 11 none
// [R7] rising fires on arrival, falling on removal, level while condition holds
// [R8] trigger modes never change the pin's electrical active level
// [R9] group one mode registers reset to zero, giving rising-edge triggering
// [R10] transmitter slip fires on every dropped or repeated transmit sample
// [R11] transmitter slip also fires on new block sync when that pin is input
// [R12] output slip fires on sample slips only while the output port is slave
// [R13] channel-status buffer fires on each D-to-E and each E-to-F completion
// [R14] receiver error fires on any receiver error; cause kept elsewhere
// [R15] user-data buffer sources fire on transfers only in block mode
// [R16] q-subcode source fires when a new complete block is readable
// [R17] host must read the whole q-subcode block within 588 frames
// [R18] status one: tx slip 7, out slip 6, cs bits 2 and 1, error 0
// [R19] status two: user D-to-E 3, user E-to-F 2, q-subcode 1
// [R20] polarity field: 00 high, 01 low push-pull, 10 open-drain low; resets 00
// [R21] group two has its own mode pair at 0dh and 0eh, reset zero
// [R22] pin active while any unmasked status bit is pending, at chosen polarity
package aix_pkg;
    localparam logic [6:0] ADDR_CONTROL1 = 7'h01;
    localparam logic [6:0] ADDR_STATUS1 = 7'h07;
    localparam logic [6:0] ADDR_STATUS2 = 7'h08;
    localparam logic [6:0] ADDR_MASK1 = 7'h09;
    localparam logic [6:0] ADDR_MODE1_HIGH = 7'h0a;
    localparam logic [6:0] ADDR_MODE1_LOW = 7'h0b;
    localparam logic [6:0] ADDR_MASK2 = 7'h0c;
    localparam logic [6:0] ADDR_MODE2_HIGH = 7'h0d;
    localparam logic [6:0] ADDR_MODE2_LOW = 7'h0e;

    localparam int BIT_TX_SLIP = 7;
    localparam int BIT_OUT_SLIP = 6;
    localparam int BIT_CS_D_TO_E = 2;
    localparam int BIT_CS_E_TO_F = 1;
    localparam int BIT_RX_FAULT = 0;
    localparam int BIT_UD_D_TO_E = 3;
    localparam int BIT_UD_E_TO_F = 2;
    localparam int BIT_Q_SUBCODE = 1;
    localparam int POL_LSB = 1;

    localparam logic [7:0] VALID1 = 8'hc7;
    localparam logic [7:0] VALID2 = 8'h0e;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_POL = 2'h0;

    localparam logic [1:0] MODE_RISE = 2'h0;
    localparam logic [1:0] MODE_FALL = 2'h1;
    localparam logic [1:0] MODE_LEVEL = 2'h2;

    typedef enum logic [1:0] {
        POL_ACTIVE_HIGH = 2'h0,
        POL_ACTIVE_LOW = 2'h1,
        POL_OPEN_DRAIN = 2'h2,
        POL_RESERVED = 2'h3
    } aix_pol_type;

    typedef struct packed {
        logic txSampleSlip;
        logic txBlockSync;
        logic txBlockSyncIsOutput;
        logic outPortSlip;
        logic outPortMaster;
        logic csDtoEDone;
        logic csEtoFDone;
        logic receiverFaultFlag;
        logic udDtoEDone;
        logic udEtoFDone;
        logic udBlockMode;
        logic qSubcodeReady;
    } aix_src_type;

    typedef struct packed {
        logic [6:0] addr;
        logic wrEn;
        logic [7:0] wrData;
        logic rdEn;
    } aix_req_type;
endpackage
